// ==== common/smsel_pkg.sv ====
// Package for the startup operation mode selector.
// Shared by the design and its bench; no imports are assumed.
package smsel_pkg;
	// Operating modes, binary coded.
	typedef enum logic [1:0] {
		SMSEL_EXT = 2'b00,
		SMSEL_CON = 2'b01,
		SMSEL_NET = 2'b10,
		SMSEL_CMB = 2'b11
	} smsel_mode_t;
	// Register byte offsets on the APB bus.
	localparam logic [11:0] SMSEL_OFS_GEN = 12'h000;
	localparam logic [11:0] SMSEL_OFS_STU = 12'h004;
	localparam logic [11:0] SMSEL_OFS_EXT = 12'h008;
	localparam logic [11:0] SMSEL_OFS_CTL = 12'h00C;
	localparam logic [11:0] SMSEL_OFS_STA = 12'h010;
	// Field widths and reset values.
	localparam int SMSEL_GEN_W = 3;
	localparam int SMSEL_STU_W = 4;
	localparam logic [2:0] SMSEL_GEN_RST = 3'h0;
	localparam logic [3:0] SMSEL_STU_RST = 4'h0;
	localparam logic [7:0] SMSEL_EXT_RST = 8'h00;
	// Legal startup selector values.
	localparam logic [3:0] SMSEL_STU_0 = 4'h0;
	localparam logic [3:0] SMSEL_STU_1 = 4'h1;
	localparam logic [3:0] SMSEL_STU_10 = 4'hA;
	// Control register field positions: bit 0 request valid, bits 2:1 target mode.
	localparam int SMSEL_CTL_REQ = 0;
	localparam int SMSEL_CTL_TGT = 1;
	// Status register: bits 1:0 mode, bit 8 last request refused.
	localparam int SMSEL_STA_REF = 8;
endpackage : smsel_pkg

// ==== design/smsel_top.sv ====
// Startup operation mode selector with APB register access.
// Assumes pin inputs are asynchronous and synchronised here; APB on i_ref_clk.
// What this block does
// (RQ1) Startup selector accepts 0, 1, 10 only.
// (RQ2) Selector writes accepted only while motor stopped.
// (RQ3) Selectors writable only when extended setting zero.
// (RQ4) Startup 0: mode follows general selector.
// (RQ5) General 0: change via external, not direct.
// (RQ6) General 1: console mode, no changes.
// (RQ7) General 2: external/network only, no console.
// (RQ8) General 3/4: combined mode, no changes.
// (RQ9) General 6: changes allowed while running.
// (RQ10) General 7: changes need output stop on.
// (RQ11) Startup 1: network start for 0,2,6.
// (RQ12) Startup 1, general 7: stop input picks.
// (RQ13) Startup 10, general 0: console/network when stopped.
// (RQ14) Startup 10, general 2: network fixed.
// (RQ15) Startup 10, general 6: console/network while running.
// (RQ16) Startup 10 with 1,3,4,7 as startup 0.
// (RQ17) Key press or switch change toggles console/network.
// (RQ18) Same startup choice on every reset.
// (RQ19) Switch input on console, off network.
// (RQ20) Mode registered, loaded one cycle after reset.
`timescale 1ns/1ps
module smsel_top (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_motor_stopped,
	input wire logic i_output_stop_input,
	input wire logic i_console_mode_key,
	input wire logic i_console_network_switch_input,
	input wire logic i_switch_assigned,
	output logic [1:0] o_mode
);
	typedef struct packed {
		logic [2:0] gen;
		logic [3:0] stu;
		logic [7:0] extd;
		logic [1:0] mode;
		logic started;
		logic refused;
		logic [2:0] stop_s;
		logic [2:0] key_s;
		logic [2:0] sw_s;
		logic [2:0] run_s;
		logic [31:0] rdata;
	} smsel_state_t;

	smsel_state_t st;
	smsel_state_t next_st;

	// Synchronised input levels (second stage) and edges.
	logic stop_on;
	logic running;
	logic key_edge;
	logic sw_edge;
	logic wr;
	logic rd;
	logic sel_ok;
	logic [1:0] start_mode;
	logic [1:0] tgt;
	logic req;
	logic allow;
	logic bad_addr;

	assign stop_on = st.stop_s[1];
	assign running = ~st.run_s[1];
	assign key_edge = st.key_s[1] & ~st.key_s[2];
	assign sw_edge = st.sw_s[1] ^ st.sw_s[2];
	assign wr = i_psel & i_penable & i_pwrite;
	assign rd = i_psel & i_penable & ~i_pwrite;
	assign bad_addr = (i_paddr != smsel_pkg::SMSEL_OFS_GEN) &&
		(i_paddr != smsel_pkg::SMSEL_OFS_STU) &&
		(i_paddr != smsel_pkg::SMSEL_OFS_EXT) &&
		(i_paddr != smsel_pkg::SMSEL_OFS_CTL) &&
		(i_paddr != smsel_pkg::SMSEL_OFS_STA);
	// Selector writes need a stopped motor and a zero extended setting.
	assign sel_ok = ~running && (st.extd == 8'h00); // RQ2 RQ3

	// Startup mode from both selectors and the output-stop input.
	always_comb begin
		start_mode = smsel_pkg::SMSEL_EXT;
		case (st.gen)
			3'h1: start_mode = smsel_pkg::SMSEL_CON; // RQ4 RQ6
			3'h3, 3'h4: start_mode = smsel_pkg::SMSEL_CMB; // RQ8
			3'h0, 3'h2, 3'h6: begin
				if (st.stu != smsel_pkg::SMSEL_STU_0) begin
					start_mode = smsel_pkg::SMSEL_NET; // RQ11 RQ13 RQ14 RQ15
				end
			end
			3'h7: begin
				if (st.stu == smsel_pkg::SMSEL_STU_1 && stop_on) begin
					start_mode = smsel_pkg::SMSEL_NET; // RQ12
				end
			end
			default: start_mode = smsel_pkg::SMSEL_EXT; // RQ16
		endcase
	end

	// Pick the requested target: console switch events win over software.
	always_comb begin
		req = 1'b0;
		tgt = st.mode;
		if (st.stu == smsel_pkg::SMSEL_STU_10 && (st.gen == 3'h0 || st.gen == 3'h6)) begin
			if (i_switch_assigned && sw_edge) begin
				req = 1'b1; // RQ17
				tgt = st.sw_s[1] ? smsel_pkg::SMSEL_CON : smsel_pkg::SMSEL_NET; // RQ19
			end else if (key_edge) begin
				req = 1'b1; // RQ17
				tgt = (st.mode == smsel_pkg::SMSEL_CON) ? smsel_pkg::SMSEL_NET :
					smsel_pkg::SMSEL_CON;
			end
		end
		if (!req && wr && i_paddr == smsel_pkg::SMSEL_OFS_CTL && i_pwdata[smsel_pkg::SMSEL_CTL_REQ]) begin
			req = 1'b1;
			tgt = i_pwdata[smsel_pkg::SMSEL_CTL_TGT +: 2];
		end
	end

	// Permission of a requested move under the current settings.
	always_comb begin
		allow = 1'b0;
		case (st.gen)
			3'h0, 3'h6: begin
				if (st.stu == smsel_pkg::SMSEL_STU_10) begin
					allow = (tgt == smsel_pkg::SMSEL_CON || tgt == smsel_pkg::SMSEL_NET) &&
						(st.gen == 3'h6 || !running); // RQ13 RQ15
				end else begin
					allow = (tgt != smsel_pkg::SMSEL_CMB) &&
						!(st.mode == smsel_pkg::SMSEL_CON && tgt == smsel_pkg::SMSEL_NET) &&
						!(st.mode == smsel_pkg::SMSEL_NET && tgt == smsel_pkg::SMSEL_CON) &&
						(st.gen == 3'h6 || !running); // RQ5 RQ9
				end
			end
			3'h2: allow = (st.stu != smsel_pkg::SMSEL_STU_10) && !running &&
				(tgt == smsel_pkg::SMSEL_EXT || tgt == smsel_pkg::SMSEL_NET); // RQ7 RQ14
			3'h7: allow = stop_on && !running && (tgt != smsel_pkg::SMSEL_CMB) &&
				!(st.mode == smsel_pkg::SMSEL_CON && tgt == smsel_pkg::SMSEL_NET) &&
				!(st.mode == smsel_pkg::SMSEL_NET && tgt == smsel_pkg::SMSEL_CON); // RQ10
			default: allow = 1'b0; // RQ6 RQ8
		endcase
	end

	// Next-state logic for registers, synchronisers and the mode.
	always_comb begin
		next_st = st;
		next_st.stop_s = {st.stop_s[1:0], i_output_stop_input};
		next_st.key_s = {st.key_s[1:0], i_console_mode_key};
		next_st.sw_s = {st.sw_s[1:0], i_console_network_switch_input};
		next_st.run_s = {st.run_s[1:0], i_motor_stopped};
		next_st.started = 1'b1;
		if (wr && sel_ok && i_paddr == smsel_pkg::SMSEL_OFS_GEN) begin
			if (i_pwdata[2:0] != 3'h5) begin
				next_st.gen = i_pwdata[2:0]; // RQ2 RQ3
			end
		end
		if (wr && sel_ok && i_paddr == smsel_pkg::SMSEL_OFS_STU) begin
			if (i_pwdata[3:0] == smsel_pkg::SMSEL_STU_0 || i_pwdata[3:0] == smsel_pkg::SMSEL_STU_1 ||
				i_pwdata[3:0] == smsel_pkg::SMSEL_STU_10) begin
				next_st.stu = i_pwdata[3:0]; // RQ1
			end
		end
		if (wr && i_paddr == smsel_pkg::SMSEL_OFS_EXT) begin
			next_st.extd = i_pwdata[7:0];
		end
		if (!st.started) begin
			next_st.mode = start_mode; // RQ18 RQ20
		end else if (st.gen == 3'h7 && !stop_on) begin
			next_st.mode = smsel_pkg::SMSEL_EXT; // RQ10
		end else if (req) begin
			if (allow) begin
				next_st.mode = tgt; // RQ20
				next_st.refused = 1'b0;
			end else begin
				next_st.refused = 1'b1;
			end
		end
		next_st.rdata = 32'h0000_0000;
		if (rd) begin
			case (i_paddr)
				smsel_pkg::SMSEL_OFS_GEN: next_st.rdata = {29'h0000_0000, st.gen};
				smsel_pkg::SMSEL_OFS_STU: next_st.rdata = {28'h000_0000, st.stu};
				smsel_pkg::SMSEL_OFS_EXT: next_st.rdata = {24'h00_0000, st.extd};
				smsel_pkg::SMSEL_OFS_STA: next_st.rdata = {23'h00_0000, st.refused, 6'h00, st.mode};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register; reset loads constants only.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// The motor synchroniser starts at stopped, so reset shows no false run.
			st <= '{gen: smsel_pkg::SMSEL_GEN_RST, stu: smsel_pkg::SMSEL_STU_RST,
				extd: smsel_pkg::SMSEL_EXT_RST, mode: smsel_pkg::SMSEL_EXT, run_s: 3'h7,
				default: '0};
		end else begin
			st <= next_st;
		end
	end

	// APB answers in the access cycle; read data comes combinationally from next_st.rdata, not the registered copy.
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & bad_addr;
	assign o_prdata = next_st.rdata;
	assign o_mode = st.mode;

	a_mode_fixed_1: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ6
		st.started && $stable(st.gen) && st.gen == 3'h1 |=> $stable(st.mode))
		else $error("mode changed under general 1");
	a_mode_fixed_34: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ8
		st.started && (st.gen == 3'h3 || st.gen == 3'h4) && $stable(st.gen) && st.mode == smsel_pkg::SMSEL_CMB |=> $stable(st.mode))
		else $error("combined mode changed");
	a_force_ext7: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ10
		st.started && st.gen == 3'h7 && !stop_on |=> st.mode == smsel_pkg::SMSEL_EXT)
		else $error("general 7 did not force external");
	a_startup_load: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ20
		!st.started |=> st.mode == $past(start_mode) && st.started)
		else $error("startup mode not loaded");
	a_no_con_g2: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ7
		st.started && st.gen == 3'h2 && st.mode != smsel_pkg::SMSEL_CON |=> st.mode != smsel_pkg::SMSEL_CON)
		else $error("console entered under general 2");
	a_stu_legal: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ1
		st.stu == smsel_pkg::SMSEL_STU_0 || st.stu == smsel_pkg::SMSEL_STU_1 || st.stu == smsel_pkg::SMSEL_STU_10)
		else $error("illegal startup selector");
	a_sel_locked: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ2
		running |=> $stable(st.gen) && $stable(st.stu))
		else $error("selector changed while running");
	a_ext_locked: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ3
		st.extd != 8'h00 |=> $stable(st.gen) && $stable(st.stu))
		else $error("selector changed with extended set");
	a_net_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ14
		st.started && st.gen == 3'h2 && st.stu == smsel_pkg::SMSEL_STU_10 && $stable(st.gen) && $stable(st.stu) |=> $stable(st.mode))
		else $error("network mode not fixed");

	// Settings under which console and network trade places, and the forced case.
	logic pair_cfg;
	logic forced_ext;
	assign pair_cfg = (st.stu == smsel_pkg::SMSEL_STU_10) &&
		(st.gen == 3'h0 || st.gen == 3'h6);
	assign forced_ext = (st.gen == 3'h7) && !stop_on;

	// A switch edge that must move the mode to console, or to network.
	sequence s_sw_rise;
		st.started && pair_cfg && i_switch_assigned && sw_edge && st.sw_s[1] &&
			(st.gen == 3'h6 || !running);
	endsequence
	sequence s_sw_fall;
		st.started && pair_cfg && i_switch_assigned && sw_edge && !st.sw_s[1] &&
			(st.gen == 3'h6 || !running);
	endsequence
	// A key press that must toggle between console and network.
	sequence s_key_hit;
		st.started && pair_cfg && key_edge && !(i_switch_assigned && sw_edge) &&
			(st.gen == 3'h6 || !running);
	endsequence

	// Switch and key events under the console/network settings.
	a_sw_console: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ19
		s_sw_rise |=> st.mode == smsel_pkg::SMSEL_CON)
		else $error("switch on did not select console");
	a_sw_network: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ19
		s_sw_fall |=> st.mode == smsel_pkg::SMSEL_NET)
		else $error("switch off did not select network");
	a_key_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ17
		s_key_hit |=> st.mode == (($past(st.mode) == smsel_pkg::SMSEL_CON) ?
			smsel_pkg::SMSEL_NET : smsel_pkg::SMSEL_CON))
		else $error("key press did not toggle the mode");

	// Moves that the console/network settings never make.
	a_no_ext_pair: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ13
		st.started && pair_cfg && st.mode != smsel_pkg::SMSEL_EXT |=> st.mode != smsel_pkg::SMSEL_EXT)
		else $error("external entered under startup 10");

	// Refusals while the motor runs.
	a_run_hold_g0: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ5
		st.started && st.gen == 3'h0 && running |=> $stable(st.mode))
		else $error("mode changed while running under general 0");
	a_run_hold_g2: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ7
		st.started && st.gen == 3'h2 && running |=> $stable(st.mode))
		else $error("mode changed while running under general 2");
	a_run_hold_g7: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ10
		st.started && st.gen == 3'h7 && stop_on && running |=> $stable(st.mode))
		else $error("mode changed while running under general 7");

	// No direct console/network step under general 0 without startup 10.
	a_no_direct_cn: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ5
		st.started && st.gen == 3'h0 && st.stu != smsel_pkg::SMSEL_STU_10 &&
			st.mode == smsel_pkg::SMSEL_CON |=> st.mode != smsel_pkg::SMSEL_NET)
		else $error("direct move from console to network");
	a_no_direct_nc: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ5
		st.started && st.gen == 3'h0 && st.stu != smsel_pkg::SMSEL_STU_10 &&
			st.mode == smsel_pkg::SMSEL_NET |=> st.mode != smsel_pkg::SMSEL_CON)
		else $error("direct move from network to console");

	// Refusal flag and mode follow the permission decision.
	a_refuse_flag: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ6
		st.started && !forced_ext && req && !allow |=> st.refused && $stable(st.mode))
		else $error("refused request not flagged");
	a_accept_move: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ20
		st.started && !forced_ext && req && allow |=> !st.refused && st.mode == $past(tgt))
		else $error("permitted request not carried out");
	a_mode_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ20
		st.started && !forced_ext && !req |=> $stable(st.mode))
		else $error("mode changed with no request");
	a_started_stays: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ18
		st.started |=> st.started)
		else $error("startup load repeated without reset");

	// Startup choice from the two selectors.
	a_start_g1: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ6
		st.gen == 3'h1 |-> start_mode == smsel_pkg::SMSEL_CON)
		else $error("general 1 startup is not console");
	a_start_g0: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ4
		st.gen == 3'h0 && st.stu == smsel_pkg::SMSEL_STU_0 |-> start_mode == smsel_pkg::SMSEL_EXT)
		else $error("general 0 startup is not external");
	a_start_net: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ11
		(st.gen == 3'h0 || st.gen == 3'h2 || st.gen == 3'h6) &&
			st.stu != smsel_pkg::SMSEL_STU_0 |-> start_mode == smsel_pkg::SMSEL_NET)
		else $error("network startup not chosen");
	a_start_cmb: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ8
		(st.gen == 3'h3 || st.gen == 3'h4) |-> start_mode == smsel_pkg::SMSEL_CMB)
		else $error("combined startup not chosen");
	a_start_g7: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ16
		st.gen == 3'h7 && st.stu != smsel_pkg::SMSEL_STU_1 |-> start_mode == smsel_pkg::SMSEL_EXT)
		else $error("general 7 startup is not external");
	a_start_g7net: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ12
		st.gen == 3'h7 && st.stu == smsel_pkg::SMSEL_STU_1 |->
			start_mode == (stop_on ? smsel_pkg::SMSEL_NET : smsel_pkg::SMSEL_EXT))
		else $error("general 7 startup ignores output stop");

	// Selector register writes.
	a_gen_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ2
		wr && sel_ok && i_paddr == smsel_pkg::SMSEL_OFS_GEN && i_pwdata[2:0] != 3'h5 |=>
			st.gen == $past(i_pwdata[2:0]))
		else $error("general selector write lost");
	a_gen_no5: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ4
		st.gen != 3'h5)
		else $error("unused general selector value held");
	a_stu_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ1
		wr && sel_ok && i_paddr == smsel_pkg::SMSEL_OFS_STU &&
			i_pwdata[3:0] == smsel_pkg::SMSEL_STU_10 |=> st.stu == smsel_pkg::SMSEL_STU_10)
		else $error("startup selector write lost");
	a_stu_reject: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ1
		wr && i_paddr == smsel_pkg::SMSEL_OFS_STU && i_pwdata[3:0] != smsel_pkg::SMSEL_STU_0 &&
			i_pwdata[3:0] != smsel_pkg::SMSEL_STU_1 &&
			i_pwdata[3:0] != smsel_pkg::SMSEL_STU_10 |=> $stable(st.stu))
		else $error("illegal startup value taken");
	a_extd_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ3
		wr && i_paddr == smsel_pkg::SMSEL_OFS_EXT |=> st.extd == $past(i_pwdata[7:0]))
		else $error("extended setting write lost");

	// Register bus answers.
	a_slverr_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(i_psel && i_penable) |-> !o_pslverr)
		else $error("error shown outside access");
	a_slverr_bad: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_psel && i_penable && bad_addr |-> o_pslverr)
		else $error("unmapped access not flagged");
	a_slverr_map: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_psel && i_penable && i_paddr == smsel_pkg::SMSEL_OFS_STA |-> !o_pslverr)
		else $error("mapped access flagged");
	a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!rd |-> o_prdata == 32'h0000_0000)
		else $error("read data driven outside a read");
	a_read_gen: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ2
		rd && i_paddr == smsel_pkg::SMSEL_OFS_GEN |-> o_prdata == {29'h0000_0000, st.gen})
		else $error("general selector read wrong");
	a_read_stu: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ1
		rd && i_paddr == smsel_pkg::SMSEL_OFS_STU |-> o_prdata == {28'h000_0000, st.stu})
		else $error("startup selector read wrong");
	a_read_extd: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ3
		rd && i_paddr == smsel_pkg::SMSEL_OFS_EXT |-> o_prdata == {24'h00_0000, st.extd})
		else $error("extended setting read wrong");
	a_read_sta: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ20
		rd && i_paddr == smsel_pkg::SMSEL_OFS_STA |->
			o_prdata[1:0] == st.mode && o_prdata[8] == st.refused)
		else $error("status read wrong");
endmodule : smsel_top

// ==== tb/smsel_panel_model.sv ====
// Console, terminal and network-side model for the startup mode selector.
// Assumes the bench gives one-clock commands; pins move only after a rising edge.
`timescale 1ns/1ps
module smsel_panel_model (
	input wire logic i_ref_clk,
	input wire logic i_press,
	input wire logic i_sw,
	input wire logic i_stop,
	output logic o_key,
	output logic o_sw,
	output logic o_stop
);
	logic [2:0] hold;
	// All pins start released so the selector sees no event at reset.
	initial begin
		hold = 3'h0;
		o_key = 1'b0;
		o_sw = 1'b0;
		o_stop = 1'b0;
	end
	// A press is held for several clocks so that the input synchroniser sees it.
	always @(posedge i_ref_clk) begin
		if (i_press) begin
			hold <= 3'h5;
		end else if (hold != 3'h0) begin
			hold <= hold - 3'h1;
		end
		o_key <= (hold != 3'h0);
		o_sw <= i_sw;
		o_stop <= i_stop;
	end
endmodule : smsel_panel_model

// ==== tb/smsel_top_tb.sv ====
// Self-checking bench for the startup operation mode selector.
// Assumes zero-wait APB and pins that settle within six clocks.
`timescale 1ns/1ps
module smsel_top_tb;
	localparam logic [11:0] ofs_gen = smsel_pkg::SMSEL_OFS_GEN;
	localparam logic [11:0] ofs_stu = smsel_pkg::SMSEL_OFS_STU;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
	logic stopped = 1'b1, press = 1'b0, sw = 1'b0, stop = 1'b0;
	logic key_pin, sw_pin, stop_pin, pready, pslverr;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0000_0000, rdat, prdata;
	logic [1:0] mode;
	int error_cnt = 0, checks = 0, cyc = 0;
	// Free-running 10 MHz clock.
	initial begin
		forever #50 clk = ~clk;
	end
	smsel_top DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_motor_stopped(stopped),
		.i_output_stop_input(stop_pin), .i_console_mode_key(key_pin),
		.i_console_network_switch_input(sw_pin), .i_switch_assigned(1'b1), .o_mode(mode));
	smsel_panel_model panel (.i_ref_clk(clk), .i_press(press), .i_sw(sw), .i_stop(stop),
		.o_key(key_pin), .o_sw(sw_pin), .o_stop(stop_pin));
	// One APB transfer; read data and error are taken at the pready edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chk_mode(input smsel_pkg::smsel_mode_t e);
		chk("mode", {30'h0, e}, {30'h0, mode});
	endtask : chk_mode
	// Software mode request through the control register.
	task automatic req(input smsel_pkg::smsel_mode_t t);
		apb(1'b1, smsel_pkg::SMSEL_OFS_CTL, {29'h0, t, 1'b1});
		repeat (2) @(posedge clk);
	endtask : req
	task automatic complete_run();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	// Cuts a hang short well past the expected run length.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk_mode(smsel_pkg::SMSEL_EXT);
		apb(1'b0, smsel_pkg::SMSEL_OFS_STA, 32'h0000_0000);
		chk("status", 32'h0000_0000, rdat);
		apb(1'b1, smsel_pkg::SMSEL_OFS_EXT, 32'h0000_0001);
		apb(1'b1, ofs_gen, 32'h0000_0001);
		apb(1'b0, ofs_gen, 32'h0000_0000);
		chk("gen hidden", 32'h0000_0000, rdat);
		apb(1'b1, smsel_pkg::SMSEL_OFS_EXT, 32'h0000_0000);
		stopped <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, ofs_gen, 32'h0000_0002);
		apb(1'b0, ofs_gen, 32'h0000_0000);
		chk("gen running", 32'h0000_0000, rdat);
		stopped <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b1, ofs_stu, 32'h0000_0005);
		apb(1'b0, ofs_stu, 32'h0000_0000);
		chk("stu illegal", 32'h0000_0000, rdat);
		req(smsel_pkg::SMSEL_CON);
		chk_mode(smsel_pkg::SMSEL_CON);
		req(smsel_pkg::SMSEL_NET);
		apb(1'b0, smsel_pkg::SMSEL_OFS_STA, 32'h0000_0000);
		chk("direct move", 32'h0000_0101, rdat);
		req(smsel_pkg::SMSEL_EXT);
		apb(1'b1, ofs_gen, 32'h0000_0001);
		req(smsel_pkg::SMSEL_CON);
		chk_mode(smsel_pkg::SMSEL_EXT);
		apb(1'b1, ofs_gen, 32'h0000_0007);
		req(smsel_pkg::SMSEL_CON);
		chk_mode(smsel_pkg::SMSEL_EXT);
		stop <= 1'b1;
		repeat (6) @(posedge clk);
		req(smsel_pkg::SMSEL_CON);
		chk_mode(smsel_pkg::SMSEL_CON);
		stop <= 1'b0;
		repeat (6) @(posedge clk);
		chk_mode(smsel_pkg::SMSEL_EXT);
		apb(1'b1, ofs_gen, 32'h0000_0000);
		apb(1'b1, ofs_stu, 32'h0000_000A);
		apb(1'b0, ofs_stu, 32'h0000_0000);
		chk("stu ten", 32'h0000_000A, rdat);
		sw <= 1'b1;
		repeat (6) @(posedge clk);
		chk_mode(smsel_pkg::SMSEL_CON);
		sw <= 1'b0;
		repeat (6) @(posedge clk);
		chk_mode(smsel_pkg::SMSEL_NET);
		apb(1'b1, ofs_gen, 32'h0000_0006);
		stopped <= 1'b0;
		press <= 1'b1;
		@(posedge clk);
		press <= 1'b0;
		repeat (10) @(posedge clk);
		chk_mode(smsel_pkg::SMSEL_CON);
		stopped <= 1'b1;
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, err});
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk_mode(smsel_pkg::SMSEL_EXT);
		complete_run();
	end
endmodule : smsel_top_tb
